//--- rtl/cts_pkg.sv
package cts_pkg;

  // Register byte offsets
  localparam logic [7:0] CTS_CTRL_OFS    = 8'h00;
  localparam logic [7:0] CTS_PERIOD_OFS  = 8'h04;
  localparam logic [7:0] CTS_DELAY_OFS   = 8'h08;
  localparam logic [7:0] CTS_PINCFG_OFS  = 8'h0c;
  localparam logic [7:0] CTS_STATUS_OFS  = 8'h10;

  // Control register fields
  localparam int CTS_CTRL_ENABLE_BIT = 0;
  localparam int CTS_CTRL_ROLE_BIT   = 1;

  // Pin configuration fields
  localparam int CTS_PIN_DIR_BIT     = 0;
  localparam int CTS_PIN_POL_BIT     = 1;
  localparam int CTS_PIN_OFUNC_LSB   = 8;
  localparam int CTS_PIN_IFUNC_LSB   = 16;

  // Status register fields
  localparam int CTS_STAT_STATE_LSB  = 0;
  localparam int CTS_STAT_TRIG_BIT   = 4;
  localparam int CTS_STAT_LEVEL_BIT  = 5;
  localparam int CTS_STAT_COUNT_LSB  = 16;

  // Field codes
  localparam logic       CTS_ROLE_SLAVE  = 1'b0;
  localparam logic       CTS_ROLE_MASTER = 1'b1;
  localparam logic       CTS_DIR_OUT     = 1'b0;
  localparam logic       CTS_DIR_IN      = 1'b1;
  localparam logic       CTS_POL_LIGHT   = 1'b0;
  localparam logic [3:0] CTS_OFUNC_TRIG  = 4'h3;
  localparam logic [3:0] CTS_IFUNC_TRIG  = 4'h1;

  // Reset values
  localparam logic [31:0] CTS_CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] CTS_PERIOD_RST = 16'h0000;
  localparam logic [31:0] CTS_DELAY_RST  = 32'h0000_0000;
  localparam logic [31:0] CTS_PINCFG_RST = 32'h0000_0001;

  // Timing
  localparam int CTS_CLK_PERIOD_NS = 10;
  localparam int CTS_US_NS         = 1000;
  localparam int CTS_US_CYCLES     = CTS_US_NS / CTS_CLK_PERIOD_NS;
  localparam int CTS_MS_US         = 1000;
  localparam int CTS_TRIG_PULSE_US = 10;

  typedef struct packed {
    logic        enable;
    logic        role;
    logic        dir;
    logic        polarity;
    logic [3:0]  out_func;
    logic [3:0]  in_func;
    logic [15:0] period_ms;
    logic [31:0] delay_us;
  } cts_cfg_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cts_bus_req_type;

  typedef enum logic [2:0] {
    CTS_IDLE,
    CTS_MASTER,
    CTS_WAIT,
    CTS_DELAY,
    CTS_SCAN
  } cts_state_type;

endpackage : cts_pkg

//--- rtl/cts_tick.sv
`timescale 1ns/1ns
`default_nettype none

// Microsecond and millisecond ticks, restartable so periods start in phase
module cts_tick (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic restart,
  output var  logic us_tick_q,
  output var  logic ms_tick_q
);

  logic [6:0] pre_q;
  logic [6:0] pre_d;
  logic [9:0] us_q;
  logic [9:0] us_d;
  logic       us_tick_d;
  logic       ms_tick_d;

  always_comb begin
    pre_d     = pre_q + 7'h01;
    us_d      = us_q;
    us_tick_d = 1'b0;
    ms_tick_d = 1'b0;
    if (restart) begin
      // Restart cycle is the first of the new period, else each period runs one long
      pre_d = 7'h01;
      us_d  = 10'h000;
    end else if (pre_q == 7'(cts_pkg::CTS_US_CYCLES - 1)) begin
      pre_d     = 7'h00;
      us_tick_d = 1'b1;
      if (us_q == 10'(cts_pkg::CTS_MS_US - 1)) begin
        us_d      = 10'h000;
        ms_tick_d = 1'b1;
      end else begin
        us_d = us_q + 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pre_q     <= 7'h00;
      us_q      <= 10'h000;
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
    end else begin
      pre_q     <= pre_d;
      us_q      <= us_d;
      us_tick_q <= us_tick_d;
      ms_tick_q <= ms_tick_d;
    end
  end

endmodule : cts_tick

`default_nettype wire

//--- rtl/cts_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Role 1: this unit is master and generates the chain trigger.
// - Role 0: this unit is slave and waits for an external trigger.
// - Master repeats its trigger every programmed period in milliseconds.
// - Slave starts scan after trigger plus programmed microsecond delay.
// - Direction 0 drives the trigger pin; direction 1 samples it.
// - Switching behaviour 0 selects light-switching polarity, both directions.
// - Output function 3 routes the generated trigger onto the pin.
// - Input function 1 makes the pin the slave trigger source.
module cts_sync (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata_q,
  input  wire logic        trig_pin_in,
  output var  logic        trig_pin_out_q,
  output var  logic        trig_pin_oe_q,
  input  wire logic        scan_done,
  output var  logic        scan_start_q,
  output var  logic        scan_busy_q
);

  cts_pkg::cts_cfg_type   cfg_q;
  cts_pkg::cts_cfg_type   cfg_d;
  logic [31:0]            rdata_d;
  cts_pkg::cts_state_type state_q;
  cts_pkg::cts_state_type state_d;
  logic [15:0]            ms_cnt_q;
  logic [15:0]            ms_cnt_d;
  logic [31:0]            us_cnt_q;
  logic [31:0]            us_cnt_d;
  logic [7:0]             pulse_q;
  logic [7:0]             pulse_d;
  logic [15:0]            trig_cnt_q;
  logic [15:0]            trig_cnt_d;
  logic                   level_q;
  logic                   level;
  logic                   edge_seen;
  logic                   fire;
  logic                   start;
  logic                   restart;
  logic                   us_tick;
  logic                   ms_tick;
  logic                   master_ok;
  logic                   slave_ok;
  logic                   drive_pin;

  // Both roles share one prescaler; only one role runs at a time
  cts_tick u_tick (
    .core_clk  (core_clk),
    .reset     (reset),
    .restart   (restart),
    .us_tick_q (us_tick),
    .ms_tick_q (ms_tick)
  );

  // Register file
  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = 32'h0000_0000;
    if (wr) begin
      unique case (addr)
        cts_pkg::CTS_CTRL_OFS: begin
          cfg_d.enable = wdata[cts_pkg::CTS_CTRL_ENABLE_BIT];
          cfg_d.role   = wdata[cts_pkg::CTS_CTRL_ROLE_BIT];
        end
        cts_pkg::CTS_PERIOD_OFS: cfg_d.period_ms = wdata[15:0];
        cts_pkg::CTS_DELAY_OFS:  cfg_d.delay_us  = wdata;
        cts_pkg::CTS_PINCFG_OFS: begin
          cfg_d.dir      = wdata[cts_pkg::CTS_PIN_DIR_BIT];
          cfg_d.polarity = wdata[cts_pkg::CTS_PIN_POL_BIT];
          cfg_d.out_func = wdata[cts_pkg::CTS_PIN_OFUNC_LSB +: 4];
          cfg_d.in_func  = wdata[cts_pkg::CTS_PIN_IFUNC_LSB +: 4];
        end
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        cts_pkg::CTS_CTRL_OFS: begin
          rdata_d[cts_pkg::CTS_CTRL_ENABLE_BIT] = cfg_q.enable;
          rdata_d[cts_pkg::CTS_CTRL_ROLE_BIT]   = cfg_q.role;
        end
        cts_pkg::CTS_PERIOD_OFS: rdata_d[15:0] = cfg_q.period_ms;
        cts_pkg::CTS_DELAY_OFS:  rdata_d       = cfg_q.delay_us;
        cts_pkg::CTS_PINCFG_OFS: begin
          rdata_d[cts_pkg::CTS_PIN_DIR_BIT]         = cfg_q.dir;
          rdata_d[cts_pkg::CTS_PIN_POL_BIT]         = cfg_q.polarity;
          rdata_d[cts_pkg::CTS_PIN_OFUNC_LSB +: 4]  = cfg_q.out_func;
          rdata_d[cts_pkg::CTS_PIN_IFUNC_LSB +: 4]  = cfg_q.in_func;
        end
        cts_pkg::CTS_STATUS_OFS: begin
          rdata_d[cts_pkg::CTS_STAT_STATE_LSB +: 3]  = state_q;
          rdata_d[cts_pkg::CTS_STAT_TRIG_BIT]        = (pulse_q != 8'h00);
          rdata_d[cts_pkg::CTS_STAT_LEVEL_BIT]       = level_q;
          rdata_d[cts_pkg::CTS_STAT_COUNT_LSB +: 16] = trig_cnt_q;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_q <= {cts_pkg::CTS_CTRL_RST[cts_pkg::CTS_CTRL_ENABLE_BIT],
                cts_pkg::CTS_CTRL_RST[cts_pkg::CTS_CTRL_ROLE_BIT],
                cts_pkg::CTS_PINCFG_RST[cts_pkg::CTS_PIN_DIR_BIT],
                cts_pkg::CTS_PINCFG_RST[cts_pkg::CTS_PIN_POL_BIT],
                cts_pkg::CTS_PINCFG_RST[cts_pkg::CTS_PIN_OFUNC_LSB +: 4],
                cts_pkg::CTS_PINCFG_RST[cts_pkg::CTS_PIN_IFUNC_LSB +: 4],
                cts_pkg::CTS_PERIOD_RST,
                cts_pkg::CTS_DELAY_RST};
      rdata_q <= 32'h0000_0000;
    end else begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  // Role qualification; a zero period would retrigger on every ms tick, so it parks
  assign master_ok = cfg_q.enable && (cfg_q.role == cts_pkg::CTS_ROLE_MASTER)
                     && (cfg_q.period_ms != 16'h0000);
  assign slave_ok  = cfg_q.enable && (cfg_q.role == cts_pkg::CTS_ROLE_SLAVE)
                     && (cfg_q.dir == cts_pkg::CTS_DIR_IN)
                     && (cfg_q.in_func == cts_pkg::CTS_IFUNC_TRIG);
  assign drive_pin = cfg_q.enable && (cfg_q.dir == cts_pkg::CTS_DIR_OUT)
                     && (cfg_q.out_func == cts_pkg::CTS_OFUNC_TRIG);

  // Pins are synchronous; one stage suffices for edge detection
  assign level     = trig_pin_in ^ cfg_q.polarity;
  assign edge_seen = level && !level_q;

  // Sequencer
  always_comb begin
    state_d  = state_q;
    ms_cnt_d = ms_cnt_q;
    us_cnt_d = us_cnt_q;
    fire     = 1'b0;
    start    = 1'b0;
    restart  = 1'b0;
    unique case (state_q)
      cts_pkg::CTS_IDLE: begin
        if (master_ok) begin
          state_d  = cts_pkg::CTS_MASTER;
          fire     = 1'b1;
          ms_cnt_d = 16'h0000;
        end else if (slave_ok) begin
          state_d = cts_pkg::CTS_WAIT;
        end
      end
      cts_pkg::CTS_MASTER: begin
        if (!master_ok) begin
          state_d = cts_pkg::CTS_IDLE;
        end else if (ms_tick) begin
          if (ms_cnt_q + 16'h0001 >= cfg_q.period_ms) begin
            fire     = 1'b1;
            ms_cnt_d = 16'h0000;
          end else begin
            ms_cnt_d = ms_cnt_q + 16'h0001;
          end
        end
      end
      cts_pkg::CTS_WAIT: begin
        if (!slave_ok) begin
          state_d = cts_pkg::CTS_IDLE;
        end else if (edge_seen) begin
          restart  = 1'b1;
          us_cnt_d = 32'h0000_0000;
          if (cfg_q.delay_us == 32'h0000_0000) begin
            start   = 1'b1;
            state_d = cts_pkg::CTS_SCAN;
          end else begin
            state_d = cts_pkg::CTS_DELAY;
          end
        end
      end
      cts_pkg::CTS_DELAY: begin
        if (!slave_ok) begin
          state_d = cts_pkg::CTS_IDLE;
        end else if (us_tick) begin
          if (us_cnt_q + 32'h0000_0001 >= cfg_q.delay_us) begin
            start   = 1'b1;
            state_d = cts_pkg::CTS_SCAN;
          end else begin
            us_cnt_d = us_cnt_q + 32'h0000_0001;
          end
        end
      end
      cts_pkg::CTS_SCAN: begin
        // Edges arriving here or in the delay are dropped
        if (!slave_ok) begin
          state_d = cts_pkg::CTS_IDLE;
        end else if (scan_done) begin
          state_d = cts_pkg::CTS_WAIT;
        end
      end
      default: state_d = cts_pkg::CTS_IDLE;
    endcase
    if (fire) begin
      start   = 1'b1;
      restart = 1'b1;
    end
  end

  // Trigger pulse, counters and pin drive
  always_comb begin
    pulse_d    = pulse_q;
    trig_cnt_d = trig_cnt_q;
    if (fire) begin
      pulse_d = 8'(cts_pkg::CTS_TRIG_PULSE_US);
    end else if (us_tick && (pulse_q != 8'h00)) begin
      pulse_d = pulse_q - 8'h01;
    end
    if (fire || (start && (state_q != cts_pkg::CTS_MASTER) && (state_q != cts_pkg::CTS_IDLE))) begin
      trig_cnt_d = trig_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q        <= cts_pkg::CTS_IDLE;
      ms_cnt_q       <= 16'h0000;
      us_cnt_q       <= 32'h0000_0000;
      pulse_q        <= 8'h00;
      trig_cnt_q     <= 16'h0000;
      level_q        <= 1'b0;
      scan_start_q   <= 1'b0;
      scan_busy_q    <= 1'b0;
      trig_pin_out_q <= 1'b0;
      trig_pin_oe_q  <= 1'b0;
    end else begin
      state_q        <= state_d;
      ms_cnt_q       <= ms_cnt_d;
      us_cnt_q       <= us_cnt_d;
      pulse_q        <= pulse_d;
      trig_cnt_q     <= trig_cnt_d;
      level_q        <= level;
      scan_start_q   <= start;
      scan_busy_q    <= (state_d == cts_pkg::CTS_DELAY) || (state_d == cts_pkg::CTS_SCAN);
      trig_pin_out_q <= (pulse_d != 8'h00) ^ cfg_q.polarity;
      trig_pin_oe_q  <= drive_pin;
    end
  end

endmodule : cts_sync

`default_nettype wire

//--- test/cts_sync_sva.sv
`timescale 1ns/1ns
`default_nettype none
module cts_sync_sva (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata_q,
  input wire logic        trig_pin_in,
  input wire logic        trig_pin_out_q,
  input wire logic        trig_pin_oe_q,
  input wire logic        scan_done,
  input wire logic        scan_start_q,
  input wire logic        scan_busy_q
);
  logic [31:0] c_q, p_q, f_q, g_q;
  logic [10:0] a_q;
  logic        m_q, s_q;
  wire logic   mst = c_q[1:0] == 2'h3 && p_q[15:0] != 16'h0;
  wire logic   oen = !f_q[0] && f_q[11:8] == 4'h3 && c_q[0];
  wire logic   act = trig_pin_oe_q && (trig_pin_out_q ^ f_q[1]);
  // Shadow copies of the config so timing can be judged from the ports
  always_ff @(posedge core_clk) begin
    if (reset) begin
      c_q <= 32'h0;
      p_q <= 32'h0;
      f_q <= 32'h1;
      g_q <= 32'h0;
      a_q <= 11'h0;
      m_q <= 1'b0;
      s_q <= 1'b0;
    end else begin
      if (wr && addr == 8'h00) c_q <= wdata;
      if (wr && addr == 8'h04) p_q <= wdata;
      if (wr && addr == 8'h0c) f_q <= wdata;
      g_q <= scan_start_q ? 32'h1 : g_q + 32'h1;
      a_q <= act ? a_q + 11'h1 : 11'h0;
      // Any write disarms: the first period after a change is not judged
      m_q <= wr ? 1'b0 : (scan_start_q ? mst : m_q);
      s_q <= (scan_done || !scan_busy_q) ? 1'b0 : (scan_start_q ? 1'b1 : s_q);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_rd_idle; !rd |=> rdata_q == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_start_one; scan_start_q |=> !scan_start_q; endproperty
  a_start_one: assert property (p_start_one) else $error("long start");
  property p_oe_cfg; trig_pin_oe_q |-> $past(oen) || $past(oen, 2); endproperty
  a_oe_cfg: assert property (p_oe_cfg) else $error("pin driven");
  property p_out_lvl; scan_start_q && trig_pin_oe_q |-> trig_pin_out_q == !f_q[1]; endproperty
  a_out_lvl: assert property (p_out_lvl) else $error("pin level");
  property p_width; a_q != 11'h0 && !act |-> a_q >= 11'd999 && a_q <= 11'd1001; endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_period; scan_start_q && m_q |-> g_q == p_q[15:0] * 32'd100000; endproperty
  a_period: assert property (p_period) else $error("period");
  property p_busy; scan_start_q && !mst |-> scan_busy_q; endproperty
  a_busy: assert property (p_busy) else $error("slave not busy");
  property p_one_scan; scan_start_q && scan_busy_q |-> !s_q; endproperty
  a_one_scan: assert property (p_one_scan) else $error("second scan");
endmodule : cts_sync_sva
`default_nettype wire

//--- test/cts_peer.sv
`timescale 1ns/1ns
`default_nettype none
module cts_peer #(parameter int W = 50) (
  input  wire logic core_clk,
  input  wire logic fire,
  input  wire logic inv,
  input  wire logic oe,
  input  wire logic dout,
  output var  logic line
);
  int cnt;
  always_ff @(posedge core_clk) cnt <= fire ? W : (cnt > 0 ? cnt - 1 : 0);
  // Released line rests at the inactive level of the chosen polarity
  always_comb line = oe ? dout : (inv ^ (cnt != 0));
endmodule : cts_peer
`default_nettype wire

//--- test/cts_sync_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cts_sync_tb;
  logic        core_clk, reset, wr, rd, fire, inv, scan_done;
  logic        pin, pout, poe, start, busy;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata_q;
  int          mismatches, n_compared, cyc, n;
  cts_sync cts_sync_i (.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .trig_pin_in(pin), .trig_pin_out_q(pout),
    .trig_pin_oe_q(poe), .scan_done(scan_done), .scan_start_q(start), .scan_busy_q(busy));
  cts_peer cts_peer_i (.core_clk(core_clk), .fire(fire), .inv(inv), .oe(poe), .dout(pout),
    .line(pin));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // One master period plus slave tests fit well inside this
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 110000) begin
      mismatches++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk(rdata_q, e);
  endtask : rd_chk
  task automatic fire_pin;
    @(posedge core_clk);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
  endtask : fire_pin
  task automatic done_pulse;
    @(posedge core_clk);
    scan_done <= 1'b1;
    @(posedge core_clk);
    scan_done <= 1'b0;
  endtask : done_pulse
  task automatic wait_start(input int mx);
    #1 n = 0;
    while (start !== 1'b1 && n < mx) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask : wait_start
  initial begin
    {reset, wr, rd, fire, inv, scan_done} = 6'h20;
    addr = 8'h0;
    wdata = 32'h0;
    {cyc, mismatches, n_compared} = 0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h0c, 32'h1);
    rd_chk(8'h10, 32'h0);
    wr_reg(8'h14, 32'hffff_ffff);
    wr_reg(8'h10, 32'hffff_ffff);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h10, 32'h0);
    wr_reg(8'h08, 32'd3);
    rd_chk(8'h08, 32'd3);
    $display("test registers done");
    wr_reg(8'h00, 32'h1);
    fire_pin;
    wait_start(600);
    chk(n, 600);
    wr_reg(8'h0c, 32'h0001_0001);
    fire_pin;
    wait_start(600);
    chk(n, 3 * 100 + 1);
    chk(busy, 1);
    fire_pin;
    wait_start(300);
    chk(n, 300);
    done_pulse;
    wait_start(200);
    chk(n, 200);
    chk(busy, 0);
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h0c, 32'h0001_0003);
    rd_chk(8'h0c, 32'h0001_0003);
    @(posedge core_clk) inv <= 1'b1;
    wr_reg(8'h08, 32'h0);
    wr_reg(8'h00, 32'h1);
    fire_pin;
    wait_start(20);
    chk(n, 1);
    done_pulse;
    $display("test slave done");
    wr_reg(8'h00, 32'h0);
    @(posedge core_clk) inv <= 1'b0;
    wr_reg(8'h0c, 32'h0000_0300);
    wr_reg(8'h04, 32'h1);
    wr_reg(8'h00, 32'h3);
    wait_start(10);
    chk(n, 1);
    chk(poe, 1);
    chk(pout, 1);
    @(posedge core_clk);
    wait_start(100010);
    chk(n + 1, 100000);
    rd_chk(8'h10, 32'h0004_0031);
    $display("test master done");
    stop_test;
  end
endmodule : cts_sync_tb
bind cts_sync cts_sync_sva cts_sync_sva_i (.core_clk(core_clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .trig_pin_in(trig_pin_in),
  .trig_pin_out_q(trig_pin_out_q), .trig_pin_oe_q(trig_pin_oe_q), .scan_done(scan_done),
  .scan_start_q(scan_start_q), .scan_busy_q(scan_busy_q));
`default_nettype wire
